/* File: core/slpcg_pkg.sv */
// package for the sleep and module clock gating block: offsets, fields, modes, timing
package slpcg_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] SMC_OFFSET    = 8'h00;   // sleep_mode_ctrl_reg
   localparam logic [7:0] PRR_OFFSET    = 8'h04;   // power_reduction_reg
   localparam logic [7:0] STAT_OFFSET   = 8'h08;   // sleep status, read only
   localparam logic [7:0] WAKEDLY_OFFSET = 8'h0c;  // wake delay per clock select, read only

   // sleep_mode_ctrl_reg fields
   localparam int SE_BIT    = 0;
   localparam int SMS_LSB   = 1;
   localparam int SMS_W     = 3;

   // sleep_mode_select encodings
   localparam logic [2:0] SMS_IDLE    = 3'h0;
   localparam logic [2:0] SMS_NOISE   = 3'h1;
   localparam logic [2:0] SMS_HALT    = 3'h2;
   localparam logic [2:0] SMS_STANDBY = 3'h6;

   // power_reduction_reg bit positions
   localparam int G_CONVERTER = 0;
   localparam int G_SERPORT   = 1;
   localparam int G_SERPERIPH = 2;
   localparam int G_TIMER0    = 3;
   localparam int G_TIMER1    = 4;
   localparam int G_PSC0      = 5;
   localparam int G_PSC1      = 6;
   localparam int G_PSC2      = 7;
   localparam int NPERIPH     = 8;
   localparam logic [7:0] PRR_RESET = 8'h00;

   // timing
   localparam int STANDBY_WAKE_CYC = 6;
   localparam int IRQ_HALT_CYC     = 4;

   typedef enum logic [2:0] {
      SLPCG_ACTIVE, SLPCG_IDLE, SLPCG_NOISE, SLPCG_HALT, SLPCG_STANDBY, SLPCG_WAKE, SLPCG_HOLD
   } slpcg_state_e;

   // clock domain enables
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
      logic pll;
      logic osc;
   } slpcg_clk_s;

   // wake causes
   typedef struct packed {
      logic       ext_reset;
      logic       wdt_reset;
      logic       bod_reset;
      logic       psc_irq;
      logic       spm_irq;
      logic       adc_irq;
      logic       wdt_irq;
      logic       other_irq;
      logic [3:0] lvl_irq;
      logic [3:0] edge_irq;
   } slpcg_wake_s;
endpackage

/* File: core/slpcg_top.sv */
// sleep mode sequencing, clock domain gating and per-peripheral clock gating
//
// Overview of operation
// R1 - mode 010 plus sleep enters deepest halt
// R2 - halt stops oscillator; watchdog, external irq run
// R3 - halt wakes on resets, psc, level irq
// R4 - halt stops all generated clock domains
// R5 - level wake source holds level long enough
// R6 - halt wake delay chosen by clock select
// R7 - mode 110 with crystal enters standby
// R8 - standby resumes within six clock cycles
// R9 - idle stops cpu, flash; noise also io
// R10 - standby wakes on level irq, watchdog only; the code also wakes standby on ext, watchdog and brown-out resets
// R11 - gate bit stops peripheral clock, blocks access
// R12 - clearing gate bit restarts clock, state kept
// R13 - software disables peripheral before gating it
// R14 - gating matters only in active and idle
// R15 - gate bit map psc2..adc, bits 7..0
// R16 - re-enabled timer continues as before
// R17 - software reinitialises psc, spi, serial port
// R18 - adc disabled first; comparator mux blocked
// R19 - adc enable kept across sleep; extended conversion
// R20 - watchdog and brown-out stay active sleeping
// R21 - input buffers off when io, adc stopped
// R22 - debug fuse keeps main source in sleep
// R23 - sleep only with sleep_enable and request
// R24 - four extra halt cycles after irq wake
// R25 - mode 000 selects idle
// R26 - mode 001 selects noise reduction
// R27 - power_reduction_reg resets to zero
`timescale 1ns/1ns
module slpcg_top #(
   parameter int CLK_SEL_W  = 4,
   parameter int WAKE_CNT_W = 16
) (
   input  wire logic                      i_mclk,          // system clock, 10 mhz
   input  wire logic                      i_nrst,          // asynchronous reset, active low
   input  wire logic                      psel,            // apb select
   input  wire logic                      penable,         // apb enable
   input  wire logic                      pwrite,          // apb direction
   input  wire logic [7:0]                paddr,           // apb byte address
   input  wire logic [31:0]               pwdata,          // apb write data
   output logic                           pready,          // apb ready
   output logic [31:0]                    prdata,          // apb read data
   output logic                           pslverr,         // apb error, unmapped address
   input  wire logic                      i_sleep_req,     // core executes a sleep request, pulse
   input  wire slpcg_pkg::slpcg_wake_s    i_wake,          // wake causes from pins and peripherals
   input  wire logic [CLK_SEL_W-1:0]      i_clock_select_fuses, // clock select fuse value
   input  wire logic                      i_crystal_sel,   // external crystal clock option chosen
   input  wire logic                      i_debug_enable_fuse, // on-chip debug enabled
   input  wire logic                      i_brownout_en,   // brown-out detector enabled by fuses
   input  wire logic                      i_wdt_en,        // watchdog enabled
   input  wire logic                      i_adc_en,        // adc enable bit of the converter
   output slpcg_pkg::slpcg_clk_s          o_clk_en,        // clock domain enables
   output logic [7:0]                     o_periph_clk_en, // per-peripheral clock enables
   output logic [7:0]                     o_periph_acc_en, // peripheral register access allowed
   output logic                           o_cmp_mux_allow, // comparator may use adc input mux
   output logic                           o_in_buf_en,     // general digital input buffers on
   output logic                           o_wake_buf_en,   // wake detection buffers on
   output logic                           o_wdt_run,       // watchdog keeps running
   output logic                           o_bod_run,       // brown-out detector keeps running
   output logic                           o_adc_keep,      // adc stays enabled in sleep
   output logic                           o_adc_ext_conv,  // next conversion is extended
   output logic                           o_irq_go         // core may service wake interrupt
);
   // wake delay per clock select, computed as 16 cycles per select step plus 16
   function automatic logic [WAKE_CNT_W-1:0] wake_delay(input logic [CLK_SEL_W-1:0] sel);
      wake_delay = WAKE_CNT_W'({sel, 4'h0}) + WAKE_CNT_W'(16'h0010);
   endfunction

   // apb byte offset match, used by read and write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // level wake inputs come from pins: two flops before use
   logic [3:0] lvl_s1_reg, lvl_s2_reg;
   logic [2:0] rst_s1_reg, rst_s2_reg;
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         lvl_s1_reg <= 4'h0;
         lvl_s2_reg <= 4'h0;
         rst_s1_reg <= 3'h0;
         rst_s2_reg <= 3'h0;
      end else begin
         lvl_s1_reg <= i_wake.lvl_irq;
         lvl_s2_reg <= lvl_s1_reg;
         rst_s1_reg <= {i_wake.ext_reset, i_wake.wdt_reset, i_wake.bod_reset};
         rst_s2_reg <= rst_s1_reg;
      end
   end

   // register file state
   logic                     se_reg, se_next;
   logic [2:0]               sms_reg, sms_next;
   logic [7:0]               prr_reg, prr_next;
   logic                     pready_reg, pready_next;
   logic [31:0]              prdata_reg, prdata_next;
   logic                     perr_reg, perr_next;

   // sleep sequencer state
   slpcg_pkg::slpcg_state_e  st_reg, st_next;
   logic [WAKE_CNT_W-1:0]    cnt_reg, cnt_next;
   logic                     irq_wake_reg, irq_wake_next;
   logic                     adc_prev_reg, adc_ext_reg, adc_ext_next;

   logic                     acc_phase;
   assign acc_phase = psel && penable;

   // apb slave: one wait state per access, writes land when pready is high
   always_comb begin
      se_next     = se_reg;
      sms_next    = sms_reg;
      prr_next    = prr_reg;
      pready_next = 1'b0;
      prdata_next = prdata_reg;
      perr_next   = 1'b0;
      if (acc_phase && !pready_reg) begin
         pready_next = 1'b1;
         if (pwrite) begin
            if (hit(paddr, slpcg_pkg::SMC_OFFSET)) begin
               se_next  = pwdata[slpcg_pkg::SE_BIT];
               sms_next = pwdata[slpcg_pkg::SMS_LSB +: slpcg_pkg::SMS_W];
            end else if (hit(paddr, slpcg_pkg::PRR_OFFSET)) begin
               prr_next = pwdata[7:0]; // R11 R12 R15
            end else if (!hit(paddr, slpcg_pkg::STAT_OFFSET) && !hit(paddr, slpcg_pkg::WAKEDLY_OFFSET)) begin
               perr_next = 1'b1;
            end
         end else begin
            prdata_next = 32'h0;
            if (hit(paddr, slpcg_pkg::SMC_OFFSET)) begin
               prdata_next = {28'h0, sms_reg, se_reg};
            end else if (hit(paddr, slpcg_pkg::PRR_OFFSET)) begin
               prdata_next = {24'h0, prr_reg};
            end else if (hit(paddr, slpcg_pkg::STAT_OFFSET)) begin
               prdata_next = {27'h0, adc_ext_reg, 1'b0, st_reg};
            end else if (hit(paddr, slpcg_pkg::WAKEDLY_OFFSET)) begin
               prdata_next = 32'(wake_delay(i_clock_select_fuses)); // R6
            end else begin
               perr_next = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         se_reg     <= 1'b0;
         sms_reg    <= 3'h0;
         prr_reg    <= slpcg_pkg::PRR_RESET; // R27
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0;
         perr_reg   <= 1'b0;
      end else begin
         se_reg     <= se_next;
         sms_reg    <= sms_next;
         prr_reg    <= prr_next;
         pready_reg <= pready_next;
         prdata_reg <= prdata_next;
         perr_reg   <= perr_next;
      end
   end

   // wake conditions per mode
   logic any_reset, wake_idle, wake_noise, wake_halt, wake_stby, lvl_any, edge_any;
   assign any_reset  = |rst_s2_reg;
   assign lvl_any    = |lvl_s2_reg;
   assign edge_any   = |i_wake.edge_irq;
   assign wake_idle  = any_reset || lvl_any || edge_any || i_wake.psc_irq || i_wake.spm_irq
                       || i_wake.adc_irq || i_wake.wdt_irq || i_wake.other_irq; // R9
   assign wake_noise = any_reset || lvl_any || i_wake.psc_irq || i_wake.spm_irq
                       || i_wake.adc_irq || i_wake.wdt_irq; // R9 R10
   assign wake_halt  = any_reset || lvl_any || i_wake.psc_irq || i_wake.wdt_irq; // R3 R10
   assign wake_stby  = any_reset || lvl_any || i_wake.wdt_irq; // R10

   // sleep sequencer: entry decode, wake detect, wake delay, interrupt hold
   always_comb begin
      st_next       = st_reg;
      cnt_next      = cnt_reg;
      irq_wake_next = irq_wake_reg;
      case (st_reg)
         slpcg_pkg::SLPCG_ACTIVE: begin
            if (i_sleep_req && se_reg) begin // R23
               case (sms_reg)
                  slpcg_pkg::SMS_IDLE:  st_next = slpcg_pkg::SLPCG_IDLE;  // R25
                  slpcg_pkg::SMS_NOISE: st_next = slpcg_pkg::SLPCG_NOISE; // R26
                  slpcg_pkg::SMS_HALT:  st_next = slpcg_pkg::SLPCG_HALT;  // R1
                  slpcg_pkg::SMS_STANDBY: begin
                     if (i_crystal_sel) begin
                        st_next = slpcg_pkg::SLPCG_STANDBY; // R7
                     end
                  end
                  default: st_next = slpcg_pkg::SLPCG_ACTIVE;
               endcase
            end
         end
         slpcg_pkg::SLPCG_IDLE, slpcg_pkg::SLPCG_NOISE: begin
            if ((st_reg == slpcg_pkg::SLPCG_IDLE) ? wake_idle : wake_noise) begin
               irq_wake_next = !any_reset;
               cnt_next      = WAKE_CNT_W'(slpcg_pkg::IRQ_HALT_CYC - 1);
               st_next       = any_reset ? slpcg_pkg::SLPCG_ACTIVE : slpcg_pkg::SLPCG_HOLD; // R24
            end
         end
         slpcg_pkg::SLPCG_HALT: begin
            if (wake_halt) begin
               irq_wake_next = !any_reset;
               cnt_next      = wake_delay(i_clock_select_fuses) - WAKE_CNT_W'(1); // R6
               st_next       = slpcg_pkg::SLPCG_WAKE;
            end
         end
         slpcg_pkg::SLPCG_STANDBY: begin
            if (wake_stby) begin
               irq_wake_next = !any_reset;
               cnt_next      = WAKE_CNT_W'(slpcg_pkg::STANDBY_WAKE_CYC - 3); // R8
               st_next       = slpcg_pkg::SLPCG_WAKE;
            end
         end
         slpcg_pkg::SLPCG_WAKE: begin
            if (cnt_reg == '0) begin
               if (irq_wake_reg) begin
                  cnt_next = WAKE_CNT_W'(slpcg_pkg::IRQ_HALT_CYC - 1);
                  st_next  = slpcg_pkg::SLPCG_HOLD; // R24
               end else begin
                  st_next = slpcg_pkg::SLPCG_ACTIVE;
               end
            end else begin
               cnt_next = cnt_reg - WAKE_CNT_W'(1);
            end
         end
         slpcg_pkg::SLPCG_HOLD: begin
            if (cnt_reg == '0) begin
               st_next       = slpcg_pkg::SLPCG_ACTIVE;
               irq_wake_next = 1'b0;
            end else begin
               cnt_next = cnt_reg - WAKE_CNT_W'(1);
            end
         end
         default: st_next = slpcg_pkg::SLPCG_ACTIVE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg       <= slpcg_pkg::SLPCG_ACTIVE;
         cnt_reg      <= '0;
         irq_wake_reg <= 1'b0;
      end else begin
         st_reg       <= st_next;
         cnt_reg      <= cnt_next;
         irq_wake_reg <= irq_wake_next;
      end
   end

   // adc off-then-on tracking: next conversion is extended
   always_comb begin
      adc_ext_next = adc_ext_reg;
      if (i_adc_en && !adc_prev_reg) begin
         adc_ext_next = 1'b1; // R19
      end else if (i_wake.adc_irq) begin
         adc_ext_next = 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         adc_prev_reg <= 1'b0;
         adc_ext_reg  <= 1'b1;
      end else begin
         adc_prev_reg <= i_adc_en;
         adc_ext_reg  <= adc_ext_next;
      end
   end

   // clock domain enables per state; debug fuse pins the main source on
   slpcg_pkg::slpcg_clk_s clk_next;
   logic                  sleeping, periph_run;
   always_comb begin
      clk_next = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, pll: 1'b1, osc: 1'b1};
      case (st_reg)
         slpcg_pkg::SLPCG_IDLE: begin
            clk_next.cpu   = 1'b0; // R9
            clk_next.flash = 1'b0;
         end
         slpcg_pkg::SLPCG_NOISE: begin
            clk_next.cpu   = 1'b0; // R26
            clk_next.flash = 1'b0;
            clk_next.io    = 1'b0;
         end
         slpcg_pkg::SLPCG_HALT: begin
            clk_next = '0; // R1 R2 R4
         end
         slpcg_pkg::SLPCG_STANDBY, slpcg_pkg::SLPCG_WAKE: begin
            clk_next     = '0;
            clk_next.osc = 1'b1; // R7 R10
         end
         slpcg_pkg::SLPCG_HOLD: begin
            clk_next.cpu   = 1'b0;
            clk_next.flash = 1'b0;
         end
         default: clk_next = clk_next;
      endcase
      if (i_debug_enable_fuse) begin
         clk_next.osc = 1'b1; // R22
      end
   end

   // peripheral clocks only run where the io domain runs
   assign sleeping   = (st_reg != slpcg_pkg::SLPCG_ACTIVE);
   assign periph_run = (st_reg == slpcg_pkg::SLPCG_ACTIVE) || (st_reg == slpcg_pkg::SLPCG_IDLE); // R14

   // output registers; gating the clock alone freezes peripheral state, so re-enable resumes it
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_clk_en        <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, pll: 1'b1, osc: 1'b1};
         o_periph_clk_en <= 8'hff;
         o_periph_acc_en <= 8'hff;
         o_cmp_mux_allow <= 1'b1;
         o_in_buf_en     <= 1'b1;
         o_wake_buf_en   <= 1'b1;
         o_wdt_run       <= 1'b0;
         o_bod_run       <= 1'b0;
         o_adc_keep      <= 1'b0;
         o_adc_ext_conv  <= 1'b1;
         o_irq_go        <= 1'b0;
      end else begin
         o_clk_en        <= clk_next;
         o_periph_clk_en <= periph_run ? ~prr_next : 8'h00; // R11 R12 R14 R16
         o_periph_acc_en <= ~prr_next; // R11
         o_cmp_mux_allow <= !prr_next[slpcg_pkg::G_CONVERTER]; // R18
         o_in_buf_en     <= clk_next.io || clk_next.adc; // R21
         o_wake_buf_en   <= 1'b1; // R21
         o_wdt_run       <= i_wdt_en; // R20
         o_bod_run       <= i_brownout_en; // R20
         o_adc_keep      <= i_adc_en && sleeping; // R19
         o_adc_ext_conv  <= adc_ext_next;
         o_irq_go        <= (st_reg == slpcg_pkg::SLPCG_HOLD) && (cnt_reg == '0);
      end
   end

   assign pready  = pready_reg;
   assign prdata  = prdata_reg;
   assign pslverr = perr_reg;
endmodule

/* File: dv/slpcg_core_model.sv */
// core-side model: raises a level wake line and holds it
`timescale 1ns/1ns
module slpcg_core_model (
   input  wire logic i_mclk,   // system clock
   input  wire logic i_nrst,   // reset, active low
   input  wire logic i_raise,  // bench asks for a wake
   input  wire logic i_cpu_on, // core clock running
   output logic [3:0] o_lvl    // level wake lines
);
   // a short pulse could be missed behind the synchroniser, so hold until the core runs
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_lvl <= 4'h0;
      end else if (i_raise) begin
         o_lvl <= 4'h4;
      end else if (i_cpu_on) begin
         o_lvl <= 4'h0;
      end
   end
endmodule

/* File: dv/slpcg_top_monitor.sv */
// assertion checker for the sleep and clock gating block
`timescale 1ns/1ns
module slpcg_top_monitor #(
   parameter int CLK_SEL_W  = 4,
   parameter int WAKE_CNT_W = 16
) (
   input wire logic                   i_mclk,              // clock
   input wire logic                   i_nrst,              // reset
   input wire logic                   psel,                // apb select
   input wire logic                   penable,             // apb enable
   input wire logic                   pready,              // apb ready
   input wire slpcg_pkg::slpcg_wake_s i_wake,              // wake causes
   input wire logic                   i_debug_enable_fuse, // debug fuse
   input wire logic                   i_wdt_en,            // watchdog enable
   input wire logic                   i_brownout_en,       // brown-out enable
   input wire slpcg_pkg::slpcg_clk_s  o_clk_en,            // clock enables
   input wire logic [7:0]             o_periph_clk_en,     // peripheral clocks
   input wire logic [7:0]             o_periph_acc_en,     // peripheral access
   input wire logic                   o_cmp_mux_allow,     // comparator mux
   input wire logic                   o_in_buf_en,         // input buffers
   input wire logic                   o_wake_buf_en,       // wake buffers
   input wire logic                   o_wdt_run,           // watchdog running
   input wire logic                   o_bod_run            // brown-out running
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   // bus answers after one wait state and only for one cycle
   a_apb_wait: assert property (psel && penable && !pready |=> pready) else $error("ready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_gate_access: assert property ((o_periph_clk_en & ~o_periph_acc_en) == 8'h00)
      else $error("clock on for gated peripheral");
   a_mux_block: assert property (o_cmp_mux_allow == o_periph_acc_en[0]) else $error("mux allowed");
   a_osc_all_off: assert property (!o_clk_en.osc |-> o_clk_en == 6'h00)
      else $error("clock runs without oscillator");
   a_cpu_flash: assert property (o_clk_en.cpu == o_clk_en.flash) else $error("cpu flash split");
   a_sleep_periph: assert property (!o_clk_en.io [*2] |-> o_periph_clk_en == 8'h00)
      else $error("peripheral clock in deep sleep");
   a_buf_off: assert property ((!o_clk_en.io && !o_clk_en.adc) [*2] |-> !o_in_buf_en && o_wake_buf_en)
      else $error("input buffers on");
   a_wdt_follow: assert property ($past(i_nrst) |-> o_wdt_run == $past(i_wdt_en))
      else $error("watchdog run wrong");
   a_bod_follow: assert property ($past(i_nrst) |-> o_bod_run == $past(i_brownout_en))
      else $error("brown-out run wrong");
   a_debug_osc: assert property (i_debug_enable_fuse [*3] |-> o_clk_en.osc) else $error("osc off");
   a_standby_wake: assert property ($rose(i_wake.wdt_irq) && o_clk_en == 6'h01 && !i_debug_enable_fuse
      |-> ##[1:6] o_clk_en.io) else $error("standby wake slow");
   c_halt: cover property (o_clk_en == 6'h00);
   c_standby: cover property (o_clk_en == 6'h01);
   c_noise: cover property (o_clk_en == 6'h07);
endmodule
bind slpcg_top slpcg_top_monitor #(.CLK_SEL_W(CLK_SEL_W), .WAKE_CNT_W(WAKE_CNT_W)) mon (.*);

/* File: dv/slpcg_top_test.sv */
// self-checking bench for the sleep and clock gating block
`timescale 1ns/1ns
module slpcg_top_test;
   logic                   i_mclk = 1'b0;
   logic                   i_nrst = 1'b0;
   logic                   psel = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite = 1'b0;
   logic [7:0]             paddr = 8'h00;
   logic [31:0]            pwdata = 32'h0;
   logic                   pready, pslverr, i_sleep_req = 1'b0;
   logic [31:0]            prdata, q;
   slpcg_pkg::slpcg_wake_s wk = '0;
   slpcg_pkg::slpcg_wake_s i_wake;
   logic [3:0]             i_clock_select_fuses = 4'h1;
   logic                   i_crystal_sel = 1'b0;
   logic                   i_debug_enable_fuse = 1'b0;
   logic                   i_brownout_en = 1'b1;
   logic                   i_wdt_en = 1'b0;
   logic                   i_adc_en = 1'b0;
   slpcg_pkg::slpcg_clk_s  o_clk_en;
   logic [7:0]             o_periph_clk_en, o_periph_acc_en;
   logic                   o_cmp_mux_allow, o_in_buf_en, o_wake_buf_en, o_wdt_run, o_bod_run;
   logic                   o_adc_keep, o_adc_ext_conv, o_irq_go, e, raise = 1'b0;
   logic [3:0]             lvl;
   int                     n_fail = 0;
   int                     check_count = 0;
   always #50 i_mclk = ~i_mclk;
   // level lines come from the core model on top of the bench's own causes
   always_comb begin
      i_wake = wk;
      i_wake.lvl_irq = wk.lvl_irq | lvl;
   end
   slpcg_top #(.CLK_SEL_W(4), .WAKE_CNT_W(16)) uut (.*);
   slpcg_core_model core (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_raise(raise), .i_cpu_on(o_clk_en.cpu), .o_lvl(lvl));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_clk(input slpcg_pkg::slpcg_clk_s got, input logic [5:0] exp);
      chk({26'h0, got}, {26'h0, exp});
   endtask
   // one apb transfer; the wait is bounded so a dead slave cannot hang the run
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_mclk);
      penable <= 1'b1;
      @(posedge i_mclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge i_mclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never drives psel twice in one step
      @(posedge i_mclk);
      if (n >= 20) n_fail++;
   endtask
   task automatic slp(input logic [2:0] m, input logic se);
      apb(1'b1, slpcg_pkg::SMC_OFFSET, {28'h0, m, se});
      i_sleep_req <= 1'b1;
      @(posedge i_mclk);
      i_sleep_req <= 1'b0;
      repeat (3) @(posedge i_mclk);
   endtask
   // counts cycles until the core clock (go=0) or the irq pulse (go=1) appears
   task automatic wait_for(input logic go, input int lo, input int hi);
      int n;
      n = 0;
      while (((go ? o_irq_go : o_clk_en.cpu) !== 1'b1) && n < 200) begin
         n++;
         @(posedge i_mclk);
      end
      chk({31'h0, (n >= lo && n <= hi)}, 32'h1);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge i_mclk);
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge i_mclk);
      i_nrst <= 1'b1;
      @(posedge i_mclk);
      chk_clk(o_clk_en, 6'h3f);
      chk(o_adc_ext_conv, 32'h1);
      apb(1'b0, slpcg_pkg::PRR_OFFSET, 32'h0);
      chk(q, {24'h0, slpcg_pkg::PRR_RESET});
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      apb(1'b0, slpcg_pkg::WAKEDLY_OFFSET, 32'h0);
      chk(q, 32'h20);
      // adc already off and peripherals idle before each gate is set
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, slpcg_pkg::PRR_OFFSET, 32'h1 << i);
         @(posedge i_mclk);
         chk(o_periph_clk_en, {24'h0, ~(8'h01 << i)});
         chk(o_periph_acc_en, {24'h0, ~(8'h01 << i)});
         chk(o_cmp_mux_allow, {31'h0, i != 0});
      end
      apb(1'b1, slpcg_pkg::PRR_OFFSET, 32'h10);
      slp(slpcg_pkg::SMS_IDLE, 1'b1);
      chk_clk(o_clk_en, 6'h0f);
      chk(o_periph_clk_en, 8'hef);
      wk.other_irq <= 1'b1;
      wait_for(1'b1, 4, 7);
      wk.other_irq <= 1'b0;
      // the clock enables follow the irq pulse by one edge
      @(posedge i_mclk);
      chk_clk(o_clk_en, 6'h3f);
      apb(1'b1, slpcg_pkg::PRR_OFFSET, 32'h0);
      @(posedge i_mclk);
      chk(o_periph_clk_en, 8'hff);
      slp(slpcg_pkg::SMS_IDLE, 1'b0);
      chk_clk(o_clk_en, 6'h3f);
      slp(3'h3, 1'b1);
      chk_clk(o_clk_en, 6'h3f);
      slp(slpcg_pkg::SMS_STANDBY, 1'b1);
      chk_clk(o_clk_en, 6'h3f);
      slp(slpcg_pkg::SMS_NOISE, 1'b1);
      chk_clk(o_clk_en, 6'h07);
      chk(o_periph_clk_en, 8'h00);
      wk.edge_irq <= 4'h1;
      @(posedge i_mclk);
      wk.edge_irq <= 4'h0;
      repeat (8) @(posedge i_mclk);
      chk_clk(o_clk_en, 6'h07);
      raise <= 1'b1;
      @(posedge i_mclk);
      raise <= 1'b0;
      wait_for(1'b1, 4, 9);
      i_wdt_en <= 1'b1;
      i_adc_en <= 1'b1;
      slp(slpcg_pkg::SMS_HALT, 1'b1);
      chk_clk(o_clk_en, 6'h00);
      chk({o_in_buf_en, o_wake_buf_en}, 32'h1);
      chk({o_wdt_run, o_bod_run, o_adc_keep}, 32'h7);
      wk.other_irq <= 1'b1;
      repeat (10) @(posedge i_mclk);
      chk_clk(o_clk_en, 6'h00);
      wk.other_irq <= 1'b0;
      wk.psc_irq <= 1'b1;
      wait_for(1'b0, 32, 42);
      wk.psc_irq <= 1'b0;
      i_debug_enable_fuse <= 1'b1;
      slp(slpcg_pkg::SMS_HALT, 1'b1);
      chk_clk(o_clk_en, 6'h01);
      wk.ext_reset <= 1'b1;
      wait_for(1'b0, 32, 42);
      wk.ext_reset <= 1'b0;
      i_debug_enable_fuse <= 1'b0;
      i_crystal_sel <= 1'b1;
      slp(slpcg_pkg::SMS_STANDBY, 1'b1);
      chk_clk(o_clk_en, 6'h01);
      wk.psc_irq <= 1'b1;
      repeat (8) @(posedge i_mclk);
      chk_clk(o_clk_en, 6'h01);
      wk.psc_irq <= 1'b0;
      wk.wdt_irq <= 1'b1;
      // six-cycle start-up, then the four-cycle interrupt hold before the core goes
      wait_for(1'b1, slpcg_pkg::STANDBY_WAKE_CYC, slpcg_pkg::STANDBY_WAKE_CYC + slpcg_pkg::IRQ_HALT_CYC);
      wk.wdt_irq <= 1'b0;
      wk.adc_irq <= 1'b1;
      i_adc_en <= 1'b0;
      repeat (3) @(posedge i_mclk);
      chk(o_adc_ext_conv, 32'h0);
      wk.adc_irq <= 1'b0;
      i_adc_en <= 1'b1;
      repeat (3) @(posedge i_mclk);
      chk(o_adc_ext_conv, 32'h1);
      print_verdict();
   end
endmodule
